// ===== dv/sdd_peer.sv
// Purpose: Processor model acting as master of the block's register port
// Assumes: Half SCLK period of 80 ns, well above the block's sync limit
// Notes:   Released SDI shows the inverse of its last bit
`timescale 1ns/1ps
module sdd_peer (
  // Pins towards the block
  output logic      sclk,
  output logic      cs_n,
  output logic      sdi,
  input  wire logic sdo
);
  // Idle pins
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    sdi  = 1'b0;
  end
  // One frame of n clocks, MSB first; data sampled on rises
  task automatic xfer(input logic [31:0] f, input int n, output logic [15:0] rd);
    rd   = 16'h0000;
    cs_n = 1'b0;
    for (int i = 0; i < n; i++) begin
      sdi = f[31-i];
      #80 sclk = 1'b1;
      if (i >= 16) rd = {rd[14:0], sdo};
      #80 sclk = 1'b0;
    end
    #80 cs_n = 1'b1;
    sdi = ~sdi;
    #200;
  endtask : xfer
endmodule : sdd_peer

// ===== dv/sdd_top_test.sv
// Purpose: Register port and sample dump checks for the serial block
// Assumes: Outside register file answers {address, 6'h15}
// Notes:   Short sample period keeps the dump phase brief
`timescale 1ns/1ps
module sdd_top_test;
  import sdd_pkg::*;
  logic mclk, sys_rst, sclk, cs_n, sdi, dump_req, samp_valid;
  logic sclk_o, sclk_oe, cs_n_o, cs_n_oe, sdi_o, sdi_oe, sdo_o, sdo_oe, dump_active;
  logic reg_we, reg_re, reg_rd_clr;
  logic [9:0]   reg_addr;
  logic [15:0]  reg_wdata, rd, cap, we_d;
  logic [9:0]   we_a;
  logic [223:0] samp_data;
  int bad_count, checks, we_n, clr_n, re_n;
  logic sclk_d, cs_d;
  time t_last, per;
  // Clock and register file stand-in
  initial mclk = 1'b0;
  always #5 mclk = ~mclk;
  wire [15:0] reg_rdata = {reg_addr, 6'h15};
  sdd_peer peer (.sclk(sclk), .cs_n(cs_n), .sdi(sdi), .sdo(sdo_o));
  sdd_top #(.SAMPLE_CYC(200), .FIFO_DEPTH(32)) dut (
    .mclk(mclk), .sys_rst(sys_rst), .clk_en(1'b1), .sclk_i(sclk), .sclk_o(sclk_o),
    .sclk_oe(sclk_oe), .cs_n_i(cs_n), .cs_n_o(cs_n_o), .cs_n_oe(cs_n_oe), .sdi_i(sdi),
    .sdi_o(sdi_o), .sdi_oe(sdi_oe), .sdo_o(sdo_o), .sdo_oe(sdo_oe), .dump_req(dump_req),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re),
    .reg_rd_clr(reg_rd_clr), .reg_rdata(reg_rdata), .samp_valid(samp_valid),
    .samp_data(samp_data), .dump_active(dump_active));
  // Strobe watchers
  always @(posedge mclk) begin
    if (reg_we === 1'b1) begin
      we_n++;
      we_a = reg_addr;
      we_d = reg_wdata;
    end
    if (reg_rd_clr === 1'b1) clr_n++;
    if (reg_re === 1'b1) re_n++;
  end
  // Dump capture on the slave's sampling edge, select as it stood before the edge
  always @(posedge mclk) begin
    if (sclk_o === 1'b1 && sclk_d === 1'b0) begin
      if (cs_d === 1'b0) cap = {cap[14:0], sdi_oe ? sdi_o : sdo_o};
      per = $time - t_last;
      t_last = $time;
    end
    sclk_d = sclk_o;
    cs_d = cs_n_o;
  end
  task automatic cmp(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp
  task automatic acc(input logic rw, input logic [9:0] a, input logic [15:0] d, input int n);
    @(posedge mclk);
    #1 peer.xfer({rw, 5'h15, a, d}, n, rd);
  endtask : acc
  // One dump: program, request, three sample sets, stop
  task automatic dump(input logic [15:0] ctl, input logic [7:0] s_n, input logic [7:0] s_a,
                      input logic [3:0] oe_exp);
    acc(1'b0, ADDR_DUMP_CTRL, ctl, 32);
    samp_data[31:0] = {s_n, 24'h00_0000};
    samp_data[95:64] = {s_a, 24'h00_0000};
    @(posedge mclk);
    #1 dump_req = 1'b1;
    for (int k = 0; k < 3; k++) begin
      repeat (200) @(posedge mclk);
      #1 samp_valid = 1'b1;
      @(posedge mclk);
      #1 samp_valid = 1'b0;
    end
    cmp("active", 16'h0001, {15'h0000, dump_active});
    cmp("oe", {12'h000, oe_exp}, {12'h000, sclk_oe, cs_n_oe, sdi_oe, sdo_oe});
    cmp("dump", {s_n, s_a}, cap);
    @(posedge mclk);
    #1 dump_req = 1'b0;
    repeat (400) @(posedge mclk);
    cmp("stop", 16'h0001, {15'h0000, cs_n_o & ~dump_active});
    cmp("slave oe", 16'h0000, {12'h000, sclk_oe, cs_n_oe, sdi_oe, sdo_oe});
  endtask : dump
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : tally_and_finish
  // Watchdog
  initial begin
    #200000 bad_count++;
    tally_and_finish();
  end
  // Main sequence
  initial begin
    sys_rst = 1'b1;
    dump_req = 1'b0;
    samp_valid = 1'b0;
    samp_data = '0;
    repeat (20) @(posedge mclk);
    #1 sys_rst = 1'b0;
    repeat (5) @(posedge mclk);
    acc(1'b0, ADDR_DUMP_CTRL, 16'hA041, 32);
    acc(1'b0, ADDR_DUMP_CTRL, 16'h0000, 31);
    acc(1'b1, ADDR_DUMP_CTRL, 16'h0000, 32);
    cmp("ctrl", 16'hA041, rd);
    acc(1'b1, ADDR_LAST_XFER, 16'h0000, 32);
    cmp("last", 16'hA041, rd);
    acc(1'b1, 10'h005, 16'h0000, 32);
    cmp("rdata", 16'h0155, rd);
    cmp("clr", 16'h0001, clr_n[15:0]);
    acc(1'b0, 10'h123, 16'hBEEF, 32);
    cmp("we", 16'h0001, we_n[15:0]);
    cmp("wa", 16'h0123, {6'h00, we_a});
    cmp("wd", 16'hBEEF, we_d);
    cmp("re", 16'h0001, re_n[15:0]);
    dump(16'hA041, 8'hC3, 8'h5A, 4'hD);
    cmp("period", 16'h0028, per[15:0]);
    dump(16'hA171, 8'h96, 8'h3C, 4'hE);
    tally_and_finish();
  end
endmodule : sdd_top_test

// ===== src/sdd_fifo.sv
// Purpose: Flip-flop FIFO between sample feeder and serial dump engine
// Assumes: DEPTH is a power of two
// Notes:   Ready on the fill side drops when full, which stalls the feeder
`timescale 1ns/1ps
module sdd_fifo #(
  parameter int W     = 32,
  parameter int DEPTH = 32
) (
  // Clock and control
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic clk_en,
  // Streams
  sdd_stream_if.snk in_s,
  sdd_stream_if.src out_s
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem_r [DEPTH];  // Storage
  logic [AW:0]  wr_ptr_r;       // Write pointer, extra wrap bit
  logic [AW:0]  rd_ptr_r;       // Read pointer, extra wrap bit
  wire          full_w  = (wr_ptr_r[AW] != rd_ptr_r[AW]) &&
                          (wr_ptr_r[AW-1:0] == rd_ptr_r[AW-1:0]);
  wire          empty_w = (wr_ptr_r == rd_ptr_r);
  wire          push_w  = in_s.valid && !full_w;
  wire          pop_w   = out_s.ready && !empty_w;

  assign in_s.ready  = !full_w;
  assign out_s.valid = !empty_w;
  assign out_s.data  = mem_r[rd_ptr_r[AW-1:0]];

  // Pointers move only when enabled
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
    end else if (clk_en) begin
      if (push_w) wr_ptr_r <= wr_ptr_r + 1'b1;
      if (pop_w) rd_ptr_r <= rd_ptr_r + 1'b1;
    end
  end

  // Data storage, no reset needed
  always_ff @(posedge mclk) begin
    if (clk_en && push_w) mem_r[wr_ptr_r[AW-1:0]] <= in_s.data;
  end
endmodule : sdd_fifo

// ===== src/sdd_pkg.sv
// Purpose: Shared constants and types for the serial register port and sample dump
// Assumes: 16-bit registers, 10-bit decoded register address, seven sample channels
// Notes:   Samples arrive left aligned in 32-bit words; narrow widths keep the top bits
package sdd_pkg;
  // Register map of the block's own registers
  localparam logic [9:0]  ADDR_DUMP_CTRL = 10'h00E;
  localparam logic [9:0]  ADDR_LAST_XFER = 10'h00F;
  localparam int          REG_W          = 16;
  localparam int          ADDR_W         = 10;
  localparam logic [15:0] DUMP_CTRL_RST  = 16'h0000;
  // Dump control field positions
  localparam int DIV_LSB  = 0;
  localparam int DIV_W    = 4;
  localparam int DRV_BIT  = 4;
  localparam int IDLE_BIT = 5;
  localparam int WID_LSB  = 6;
  localparam int SWAP_BIT = 8;
  localparam int CH_LSB   = 9;
  localparam int NUM_CH   = 7;
  // Slave frame layout
  localparam logic [5:0] XFER_BITS = 6'h20;
  localparam logic [5:0] ADDR_LAST = 6'h0F;
  localparam logic [5:0] DATA_FROM = 6'h10;
  localparam int         RW_BIT    = 31;
  // Master sample framing
  localparam int         SAMP_W     = 32;
  localparam logic [2:0] GAP_HALVES = 3'h4;
  // Sample width table, entry per width selector code
  localparam logic [23:0] WID_TABLE = 24'h82_0218;
  // Timing: one sample period and the clock period, both in ns
  localparam int SAMPLE_PERIOD_NS = 125000;
  localparam int CLK_NS           = 10;
  localparam int SAMPLE_CYC       = SAMPLE_PERIOD_NS / CLK_NS;
  // Master serializer states, gray along idle-shift-gap
  typedef enum logic [1:0] {
    M_IDLE  = 2'b00,
    M_SHIFT = 2'b01,
    M_GAP   = 2'b11
  } sdd_mst_e;
endpackage : sdd_pkg

// ===== src/sdd_stream_if.sv
// Purpose: Valid/ready word stream between the sample feeder, FIFO and serializer
// Assumes: Transfer happens on a clock edge where valid and ready are both high
// Notes:   Data must hold steady while valid is high and ready is low
`timescale 1ns/1ps
interface sdd_stream_if #(parameter int W = 32);
  logic         valid;  // Word offered
  logic         ready;  // Word accepted
  logic [W-1:0] data;   // Word payload
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : sdd_stream_if

// ===== src/sdd_sync.sv
// Purpose: Two flip-flop synchroniser for pin inputs
// Assumes: Each bit is an independent level
// Notes:   First stage feeds only the second stage
`timescale 1ns/1ps
module sdd_sync #(
  parameter int W = 1
) (
  // Clock and control
  input  wire logic         mclk,
  input  wire logic         sys_rst,
  input  wire logic         clk_en,
  // Data
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_r;  // First stage
  // Two stages, frozen with the clock enable
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      meta_r <= '0;
      q      <= '0;
    end else if (clk_en) begin
      meta_r <= d;
      q      <= meta_r;
    end
  end
endmodule : sdd_sync

// ===== src/sdd_top.sv
// Purpose: Serial register port (slave) and sample dump engine (master)
// Assumes: Slave SCLK no faster than mclk/8; samples arrive left aligned, 8 kHz
// Notes:   Register read data from outside is valid the cycle after reg_re
// How it works
// R1 - Dump request low means register slave port
// R2 - Sample SDI on rise, drive SDO on fall
// R3 - First bit: one reads, zero writes
// R4 - Fifteen address bits, low ten decoded
// R5 - Exactly one 16-bit value per transaction
// R6 - One chip-select low period, one register
// R7 - Write only at CS rise with 32 clocks
// R8 - After 16 clocks fetch, shift, update last
// R9 - Read-clear only after last value updated
// R10 - Dump request high: master, registers refused
// R11 - Request rise starts dump within one period
// R12 - Request fall finishes current sample set
// R13 - Master SCLK is clock over 2*div+2
// R14 - Swap bit exchanges SDI and SDO directions
// R15 - Seven channel enables choose dumped channels
// R16 - First-edge-drive bit selects master clock phase
// R17 - SCLK sits at idle level while deselected
// R18 - CS released two SCLK periods between waits; CS stays low into the next word when the FIFO already holds it
// R19 - Fixed channel order, disabled ones skipped
// R20 - Sample width from selector, MSB first
// R21 - Peer programs control before raising request
// R22 - Peer waits a period after dropping request
// R23 - Width selector maps through configurable table
// R24 - Bit 15 neutral down to bit 9 C voltage
`timescale 1ns/1ps
module sdd_top #(
  parameter int SAMPLE_CYC = sdd_pkg::SAMPLE_CYC,
  parameter int FIFO_DEPTH = 32
) (
  // Clock, reset, enable
  input  wire logic                                      mclk,
  input  wire logic                                      sys_rst,
  input  wire logic                                      clk_en,
  // Serial pins
  input  wire logic                                      sclk_i,
  output logic                                           sclk_o,
  output logic                                           sclk_oe,
  input  wire logic                                      cs_n_i,
  output logic                                           cs_n_o,
  output logic                                           cs_n_oe,
  input  wire logic                                      sdi_i,
  output logic                                           sdi_o,
  output logic                                           sdi_oe,
  output logic                                           sdo_o,
  output logic                                           sdo_oe,
  input  wire logic                                      dump_req,
  // Register file of the device
  output logic [sdd_pkg::ADDR_W-1:0]                     reg_addr,
  output logic [sdd_pkg::REG_W-1:0]                      reg_wdata,
  output logic                                           reg_we,
  output logic                                           reg_re,
  output logic                                           reg_rd_clr,
  input  wire logic [sdd_pkg::REG_W-1:0]                 reg_rdata,
  // Sample source
  input  wire logic                                      samp_valid,
  input  wire logic [sdd_pkg::NUM_CH*sdd_pkg::SAMP_W-1:0] samp_data,
  // Status
  output logic                                           dump_active
);
  import sdd_pkg::*;

  // Synchronised pins
  logic sclk_s, cs_act_s, sdi_s, dreq_s;  // Select synced active high: reset reads idle
  logic sclk_q, cs_n_q, dreq_q;  // Previous synced values for edges
  sdd_sync #(.W(4)) u_sync (
    .mclk    (mclk),
    .sys_rst (sys_rst),
    .clk_en  (clk_en),
    .d       ({sclk_i, ~cs_n_i, sdi_i, dump_req}),
    .q       ({sclk_s, cs_act_s, sdi_s, dreq_s})
  );
  // Back to active low; no false select or CS rise after reset
  wire cs_n_s = !cs_act_s;

  // Registers of the block
  logic [15:0] dump_ctrl_r;   // Dump control
  logic [15:0] last_xfer_r;   // Last transferred value
  logic        mode_master_r; // Interface in dump mode
  // Slave side state
  logic [5:0]  bit_cnt_r;     // SCLK rises in this CS low period
  logic [31:0] rx_r;          // Received frame
  logic [15:0] tx_r;          // Read data being shifted out
  logic        sbit_r;        // Slave output bit
  logic        rd_fetch_r;    // Read fetch cycle
  logic        rd_load_r;     // Read data load cycle
  logic        rd_local_r;    // Read hits a block register
  logic [15:0] local_rd_r;    // Local read value
  // Master side state
  sdd_mst_e    mst_r;
  logic [3:0]  div_cnt_r;     // Half-period counter
  logic [6:0]  edge_cnt_r;    // SCLK edges in current word
  logic [2:0]  gap_cnt_r;     // Half periods with CS released
  logic [31:0] sh_r;          // Sample shift register
  logic        msclk_r;       // Master SCLK level
  logic        mcs_n_r;       // Master chip select
  logic        feed_on_r;     // Accepting new sample sets
  logic        feed_busy_r;   // Walking one sample set
  logic [2:0]  ch_r;          // Channel being pushed
  logic [NUM_CH*SAMP_W-1:0] hold_r;  // Latched sample set

  // Slave decode
  wire        slave_act = !mode_master_r && !cs_n_s;                       // R1 R10
  wire        s_rise    = slave_act && sclk_s && !sclk_q;                  // R2
  wire        s_fall    = slave_act && !sclk_s && sclk_q;                  // R2
  wire        cs_rise   = !mode_master_r && cs_n_s && !cs_n_q;             // R6
  wire        addr_done = s_rise && (bit_cnt_r == ADDR_LAST);             // R8
  wire        rd_go     = addr_done && rx_r[14];                          // R3
  wire [9:0]  rd_addr   = {rx_r[8:0], sdi_s};                             // R4
  wire [9:0]  wr_addr   = rx_r[25:16];                                    // R4
  wire        wr_ok     = cs_rise && (bit_cnt_r == XFER_BITS) && !rx_r[RW_BIT]; // R7 R5
  wire        wr_ctrl   = wr_ok && (wr_addr == ADDR_DUMP_CTRL);
  wire        wr_ext    = wr_ok && (wr_addr != ADDR_DUMP_CTRL) && (wr_addr != ADDR_LAST_XFER);
  wire        rd_is_loc = (rd_addr == ADDR_DUMP_CTRL) || (rd_addr == ADDR_LAST_XFER);
  wire [15:0] rd_data   = rd_local_r ? local_rd_r : reg_rdata;

  // Slave bit counter and receive shift
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      bit_cnt_r <= '0;
      rx_r      <= '0;
    end else if (clk_en) begin
      if (cs_n_s) bit_cnt_r <= '0;
      else if (s_rise && bit_cnt_r != 6'h3F) bit_cnt_r <= bit_cnt_r + 6'h01;
      if (s_rise) rx_r <= {rx_r[30:0], sdi_s};                            // R2
    end
  end

  // Read pipeline: fetch, load, then clear strobe
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      rd_fetch_r <= 1'b0;
      rd_load_r  <= 1'b0;
      rd_local_r <= 1'b0;
      local_rd_r <= '0;
      reg_re     <= 1'b0;
      reg_rd_clr <= 1'b0;
    end else if (clk_en) begin
      rd_fetch_r <= rd_go;
      rd_load_r  <= rd_fetch_r;
      reg_re     <= rd_go && !rd_is_loc;                                  // R8
      reg_rd_clr <= rd_load_r && !rd_local_r;                             // R9
      if (rd_go) begin
        rd_local_r <= rd_is_loc;
        local_rd_r <= (rd_addr == ADDR_DUMP_CTRL) ? dump_ctrl_r : last_xfer_r;
      end
    end
  end

  // Register address and write strobe towards the register file
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      reg_addr  <= '0;
      reg_wdata <= '0;
      reg_we    <= 1'b0;
    end else if (clk_en) begin
      reg_we <= wr_ext;                                                   // R7
      if (rd_go) reg_addr <= rd_addr;
      else if (wr_ok) reg_addr <= wr_addr;
      if (wr_ok) reg_wdata <= rx_r[15:0];
    end
  end

  // Block registers; a write through the port lands only at CS rise
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      dump_ctrl_r <= DUMP_CTRL_RST;
      last_xfer_r <= '0;
    end else if (clk_en) begin
      if (wr_ctrl) dump_ctrl_r <= rx_r[15:0];                             // R7
      if (wr_ok) last_xfer_r <= rx_r[15:0];
      else if (rd_load_r) last_xfer_r <= rd_data;                         // R8
    end
  end

  // Slave SDO shift; changes on falling SCLK once address is in
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      tx_r   <= '0;
      sbit_r <= 1'b0;
    end else if (clk_en) begin
      if (rd_load_r) tx_r <= rd_data;                                     // R8
      else if (s_fall && bit_cnt_r >= DATA_FROM) begin                    // R2
        sbit_r <= tx_r[15];
        tx_r   <= {tx_r[14:0], 1'b0};
      end
    end
  end

  // Edge history and mode: request rise enters dump, drain leaves it
  wire dump_start = dreq_s && !dreq_q && !mode_master_r && cs_n_s;        // R11
  wire fifo_empty;
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      sclk_q        <= 1'b0;
      cs_n_q        <= 1'b1;
      dreq_q        <= 1'b0;
      mode_master_r <= 1'b0;
    end else if (clk_en) begin
      sclk_q <= sclk_s;
      cs_n_q <= cs_n_s;
      dreq_q <= dreq_s;
      if (dump_start) mode_master_r <= 1'b1;                              // R10
      else if (!feed_on_r && fifo_empty && mst_r == M_IDLE) mode_master_r <= 1'b0; // R12
    end
  end

  // Sample feeder into the FIFO
  sdd_stream_if #(.W(SAMP_W)) fin_s ();
  sdd_stream_if #(.W(SAMP_W)) fout_s ();
  wire ch_en    = dump_ctrl_r[CH_LSB + NUM_CH - 1 - int'(ch_r)];          // R24 R15
  wire ch_step  = feed_busy_r && (!ch_en || fin_s.ready);
  assign fin_s.valid = feed_busy_r && ch_en;                              // R15
  assign fin_s.data  = hold_r[SAMP_W*int'(ch_r) +: SAMP_W];               // R19

  // Latch a set on each sample strobe, walk channels in order
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      feed_on_r   <= 1'b0;
      feed_busy_r <= 1'b0;
      ch_r        <= '0;
      hold_r      <= '0;
    end else if (clk_en) begin
      if (dump_start) feed_on_r <= 1'b1;                                  // R11
      else if (!dreq_s && !feed_busy_r) feed_on_r <= 1'b0;                // R12
      if (samp_valid && feed_on_r && dreq_s && !feed_busy_r) begin
        hold_r      <= samp_data;
        feed_busy_r <= 1'b1;
        ch_r        <= '0;
      end else if (ch_step) begin                                         // R19
        ch_r <= ch_r + 3'h1;
        if (ch_r == 3'(NUM_CH - 1)) feed_busy_r <= 1'b0;
      end
    end
  end

  sdd_fifo #(.W(SAMP_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .mclk    (mclk),
    .sys_rst (sys_rst),
    .clk_en  (clk_en),
    .in_s    (fin_s),
    .out_s   (fout_s)
  );
  assign fifo_empty = !fout_s.valid;

  // Master decode
  wire [3:0] div_w    = dump_ctrl_r[DIV_LSB +: DIV_W];
  wire       tick     = (div_cnt_r == div_w);                             // R13
  wire       drv1     = dump_ctrl_r[DRV_BIT];
  wire       idle_lvl = dump_ctrl_r[IDLE_BIT];
  wire [1:0] wsel     = dump_ctrl_r[WID_LSB +: 2];
  wire [6:0] wid_w    = {1'b0, WID_TABLE[6*int'(wsel) +: 6]};             // R23 R20
  wire       last_e   = (edge_cnt_r == 7'((wid_w << 1) - 7'h01));
  wire       shift_e  = drv1 ? (edge_cnt_r[0] == 1'b0 && edge_cnt_r != 7'h00)
                             : edge_cnt_r[0];                             // R16
  wire       take_new = mode_master_r && fout_s.valid &&
                        ((mst_r == M_IDLE) || (mst_r == M_SHIFT && tick && last_e));
  assign fout_s.ready = take_new;

  // Half-period divider, runs only while shifting or gapping
  always_ff @(posedge mclk) begin
    if (sys_rst) div_cnt_r <= '0;
    else if (clk_en) div_cnt_r <= (mst_r == M_IDLE || tick) ? 4'h0 : div_cnt_r + 4'h1;
  end

  // Master serializer
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      mst_r      <= M_IDLE;
      edge_cnt_r <= '0;
      gap_cnt_r  <= '0;
      sh_r       <= '0;
      msclk_r    <= 1'b0;
      mcs_n_r    <= 1'b1;
    end else if (clk_en) begin
      case (mst_r)
        M_IDLE: begin
          msclk_r <= idle_lvl;                                            // R17
          mcs_n_r <= 1'b1;
          if (take_new) begin
            sh_r       <= fout_s.data;
            edge_cnt_r <= '0;
            mcs_n_r    <= 1'b0;
            mst_r      <= M_SHIFT;
          end
        end
        M_SHIFT: begin
          if (tick) begin
            msclk_r    <= ~msclk_r;                                       // R13
            edge_cnt_r <= edge_cnt_r + 7'h01;
            if (shift_e) sh_r <= {sh_r[30:0], 1'b0};                      // R20
            if (last_e && take_new) begin
              sh_r       <= fout_s.data;
              edge_cnt_r <= '0;
            end else if (last_e) begin
              mcs_n_r   <= 1'b1;                                          // R18
              gap_cnt_r <= '0;
              mst_r     <= M_GAP;
            end
          end
        end
        M_GAP: begin
          msclk_r <= idle_lvl;                                            // R17
          if (tick) gap_cnt_r <= gap_cnt_r + 3'h1;
          if (tick && gap_cnt_r == GAP_HALVES - 3'h1) mst_r <= M_IDLE;    // R18
        end
        default: mst_r <= M_IDLE;
      endcase
    end
  end

  // Pin stage: every pin output straight from a flop
  wire swap = dump_ctrl_r[SWAP_BIT];
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      sclk_o <= 1'b0; sclk_oe <= 1'b0; cs_n_o <= 1'b1; cs_n_oe <= 1'b0;
      sdi_o  <= 1'b0; sdi_oe  <= 1'b0; sdo_o  <= 1'b0; sdo_oe  <= 1'b0;
      dump_active <= 1'b0;
    end else if (clk_en) begin
      sclk_o      <= msclk_r;
      sclk_oe     <= mode_master_r;                                       // R1
      cs_n_o      <= mcs_n_r;
      cs_n_oe     <= mode_master_r;
      sdi_o       <= sh_r[SAMP_W-1];
      sdi_oe      <= mode_master_r && swap;                               // R14
      sdo_o       <= mode_master_r ? sh_r[SAMP_W-1] : sbit_r;
      sdo_oe      <= mode_master_r ? !swap : slave_act;                   // R14
      dump_active <= mode_master_r;
    end
  end

  // Checks
  logic [15:0] wait_cnt_r;  // Dump-mode cycles since dump start or since the last frame ended
  always_ff @(posedge mclk) begin
    if (sys_rst || !mode_master_r || !mcs_n_r) wait_cnt_r <= '0;
    else if (clk_en && wait_cnt_r != 16'hFFFF) wait_cnt_r <= wait_cnt_r + 16'h0001;
  end

  a_write_exact32: assert property (@(posedge mclk) disable iff (sys_rst) // R7
    $rose(reg_we) |-> $past(bit_cnt_r) == XFER_BITS && $past(cs_rise))
    else $error("write strobe without exactly 32 clocks");
  a_read_after16: assert property (@(posedge mclk) disable iff (sys_rst) // R8
    $rose(reg_re) |-> $past(bit_cnt_r) == ADDR_LAST && $past(rx_r[14]))
    else $error("read fetch not at address end");
  a_clear_after_last: assert property (@(posedge mclk) disable iff (sys_rst) // R9
    $rose(reg_rd_clr) |-> $past(rd_load_r) && !$past(rd_local_r))
    else $error("read clear before last value update");
  a_refuse_master: assert property (@(posedge mclk) disable iff (sys_rst) // R10
    $past(mode_master_r) && mode_master_r |-> !$rose(reg_we) && !$rose(reg_re))
    else $error("register access while dumping");
  a_slave_pins_in: assert property (@(posedge mclk) disable iff (sys_rst) // R1
    clk_en && !mode_master_r |=> !cs_n_oe && !sclk_oe)
    else $error("slave mode drives clock or select");
  a_sclk_idle: assert property (@(posedge mclk) disable iff (sys_rst) // R17
    mode_master_r && mcs_n_r && mst_r != M_IDLE |-> msclk_r == idle_lvl)
    else $error("master clock not idle while deselected");
  a_gap_min: assert property (@(posedge mclk) disable iff (sys_rst) // R18
    $rose(mcs_n_r) && mode_master_r |-> mcs_n_r [*4])
    else $error("chip select gap too short");
  a_div_rate: assert property (@(posedge mclk) disable iff (sys_rst) // R13
    $changed(msclk_r) && $past(mst_r) == M_SHIFT |-> $past(div_cnt_r == div_w))
    else $error("master clock edge off divider");
  a_swap_dir: assert property (@(posedge mclk) disable iff (sys_rst) // R14
    clk_en && mode_master_r && swap |=> sdi_oe && !sdo_oe)
    else $error("swapped direction not applied");
  a_stop_set: assert property (@(posedge mclk) disable iff (sys_rst) // R12
    $fell(feed_on_r) |-> $past(!feed_busy_r) && !$past(dreq_s))
    else $error("dump stopped inside a sample set");
  a_first_sample: assert property (@(posedge mclk) disable iff (sys_rst) // R11
    wait_cnt_r <= 16'(2 * SAMPLE_CYC))
    else $error("no frame within sample periods of start");

  c_write: cover property (@(posedge mclk) disable iff (sys_rst) $rose(reg_we));
  c_read: cover property (@(posedge mclk) disable iff (sys_rst) $rose(reg_rd_clr));
  c_dump: cover property (@(posedge mclk) disable iff (sys_rst) $fell(mcs_n_r));
  c_gap: cover property (@(posedge mclk) disable iff (sys_rst) mst_r == M_GAP);
endmodule : sdd_top
